//--- hw/isap_master.sv
/*
 * Bus master end: runs byte write, current-address read and random/sequential
 * read sequences, makes the serial clock by dividing clock_in, and buffers read
 * bytes in a FIFO; a full FIFO holds the bus clock low until space frees.
 * Assumes one memory target on the bus and no clock stretching by it.
 */
`timescale 1ns/1ns
module isap_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = isap_pkg::FIFO_DEPTH
) (
   input  wire logic             clock_in,
   input  wire logic             nrst_in,
   input  wire logic             ce_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW:0]      wp_q;
   logic [AW:0]      rp_q;
   logic             push;
   logic             pop;

   assign in_ready_out  = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
   assign out_valid_out = (wp_q != rp_q);
   assign push          = ce_in & in_valid_in & in_ready_out;
   assign pop           = ce_in & out_valid_out & out_ready_in;
   assign out_data_out  = store[rp_q[AW-1:0]];

   always_ff @(posedge clock_in)
   begin
      if (push)
         store[wp_q[AW-1:0]] <= in_data_in;
   end

   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         wp_q <= '0;
         rp_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= (AW+1)'(wp_q + 1'b1);
         if (pop)
            rp_q <= (AW+1)'(rp_q + 1'b1);
      end
   end
endmodule : isap_fifo

module isap_master #(
   parameter logic [6:0] DEV_ADDR = isap_pkg::TARGET_ADDR
) (
   input  wire logic       clock_in,
   input  wire logic       nrst_in,
   input  wire logic       ce_in,
   isap_bus_if.host        bus,
   input  wire logic       cmd_valid_in,
   output logic            cmd_ready_out,
   input  wire logic [1:0] cmd_op_in,
   input  wire logic [6:0] cmd_addr_in,
   input  wire logic [7:0] cmd_data_in,
   input  wire logic [6:0] cmd_len_in,
   output logic            rd_valid_out,
   input  wire logic       rd_ready_in,
   output logic [7:0]      rd_data_out,
   output logic            done_out,
   output logic            nack_out
);
   localparam logic [8:0] QTR = 9'(isap_pkg::QTR_CYC);

   isap_pkg::isap_hst_t st_q;
   logic [8:0] div_q;
   logic [1:0] q_q;
   logic [3:0] bit_q;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic [1:0] kind_q;
   logic       rdph_q;
   logic [1:0] op_q;
   logic [6:0] addr_q;
   logic [7:0] data_q;
   logic [6:0] left_q;
   logic       ack_q;
   logic       scl_oe_q;
   logic       sda_oe_q;
   logic [1:0] sda_sync_q;
   logic       tick;
   logic       stall;
   logic       adv;
   logic       push;
   logic       fifo_ready;

   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
         sda_sync_q <= 2'h3;
      else if (ce_in)
         sda_sync_q <= {sda_sync_q[0], bus.sda_line};
   end

   // quarter-bit divider; the bus clock is ours, so no second domain
   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
         div_q <= 9'h000;
      else if (ce_in)
         div_q <= (st_q == isap_pkg::ISAP_H_IDLE || tick) ? 9'h000 : 9'(div_q + 9'h001);
   end

   assign tick  = ce_in && st_q != isap_pkg::ISAP_H_IDLE && div_q == 9'(QTR - 9'h001);
   assign stall = st_q == isap_pkg::ISAP_H_RX && bit_q == isap_pkg::ACK_BIT && q_q == 2'h0 && !fifo_ready;
   assign adv   = tick && !stall;
   assign push  = adv && st_q == isap_pkg::ISAP_H_RX && bit_q == isap_pkg::ACK_BIT && q_q == 2'h0;

   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         st_q <= isap_pkg::ISAP_H_IDLE;
         q_q <= 2'h0;
         bit_q <= 4'h0;
         tx_q <= 8'h00;
         rx_q <= 8'h00;
         kind_q <= 2'h0;
         rdph_q <= 1'b0;
         op_q <= 2'h0;
         addr_q <= 7'h00;
         data_q <= 8'h00;
         left_q <= 7'h00;
         ack_q <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         done_out <= 1'b0;
         nack_out <= 1'b0;
      end
      else if (ce_in)
      begin
         done_out <= 1'b0;
         if (st_q == isap_pkg::ISAP_H_IDLE)
         begin
            if (cmd_valid_in)
            begin
               op_q     <= cmd_op_in;
               addr_q   <= cmd_addr_in;
               data_q   <= cmd_data_in;
               left_q   <= (cmd_len_in == 7'h00) ? 7'h01 : cmd_len_in;
               rdph_q   <= (cmd_op_in == isap_pkg::ISAP_OP_CUR);
               nack_out <= 1'b0;
               q_q      <= 2'h0;
               st_q     <= isap_pkg::ISAP_H_START;
            end
         end
         else if (adv)
         begin
            q_q <= 2'(q_q + 2'h1);
            case (st_q)
               isap_pkg::ISAP_H_START:
               begin
                  case (q_q)
                     2'h0: sda_oe_q <= 1'b0;
                     2'h1: scl_oe_q <= 1'b0;
                     2'h2: sda_oe_q <= 1'b1;
                     default:
                     begin
                        scl_oe_q <= 1'b1;
                        tx_q     <= {DEV_ADDR, rdph_q};
                        kind_q   <= 2'h0;
                        bit_q    <= 4'h0;
                        st_q     <= isap_pkg::ISAP_H_TX;
                     end
                  endcase
               end
               isap_pkg::ISAP_H_TX, isap_pkg::ISAP_H_RX:
               begin
                  case (q_q)
                     2'h0:
                     begin
                        if (bit_q == isap_pkg::ACK_BIT)
                           sda_oe_q <= (st_q == isap_pkg::ISAP_H_RX) && left_q != 7'h01;
                        else
                           sda_oe_q <= (st_q == isap_pkg::ISAP_H_TX) && !tx_q[7];
                     end
                     2'h1: scl_oe_q <= 1'b0;
                     2'h2:
                     begin
                        if (bit_q == isap_pkg::ACK_BIT)
                           ack_q <= ~sda_sync_q[1];
                        else if (st_q == isap_pkg::ISAP_H_TX)
                           tx_q <= {tx_q[6:0], 1'b0};
                        else
                           rx_q <= {rx_q[6:0], sda_sync_q[1]};
                     end
                     default:
                     begin
                        scl_oe_q <= 1'b1;
                        bit_q    <= (bit_q == isap_pkg::ACK_BIT) ? 4'h0 : 4'(bit_q + 4'h1);
                        if (bit_q == isap_pkg::ACK_BIT && st_q == isap_pkg::ISAP_H_RX)
                        begin
                           left_q <= 7'(left_q - 7'h01);
                           if (left_q == 7'h01)
                              st_q <= isap_pkg::ISAP_H_STOP;
                        end
                        else if (bit_q == isap_pkg::ACK_BIT && !ack_q)
                        begin
                           nack_out <= 1'b1;
                           st_q     <= isap_pkg::ISAP_H_STOP;
                        end
                        else if (bit_q == isap_pkg::ACK_BIT)
                        begin
                           kind_q <= 2'(kind_q + 2'h1);
                           if (kind_q == 2'h0 && rdph_q)
                              st_q <= isap_pkg::ISAP_H_RX;
                           else if (kind_q == 2'h0)
                              tx_q <= {1'b0, addr_q};
                           else if (kind_q == 2'h1 && op_q == isap_pkg::ISAP_OP_WRITE)
                              tx_q <= data_q;
                           else if (kind_q == 2'h1)
                           begin
                              rdph_q <= 1'b1;
                              st_q   <= isap_pkg::ISAP_H_START;
                           end
                           else
                              st_q <= isap_pkg::ISAP_H_STOP;
                        end
                     end
                  endcase
               end
               isap_pkg::ISAP_H_STOP:
               begin
                  case (q_q)
                     2'h0: sda_oe_q <= 1'b1;
                     2'h1: scl_oe_q <= 1'b0;
                     2'h2: sda_oe_q <= 1'b0;
                     default:
                     begin
                        done_out <= 1'b1;
                        st_q     <= isap_pkg::ISAP_H_IDLE;
                     end
                  endcase
               end
               default: st_q <= isap_pkg::ISAP_H_IDLE;
            endcase
         end
      end
   end

   isap_fifo #(.WIDTH(8), .DEPTH(isap_pkg::FIFO_DEPTH)) u_rd_fifo (
      .clock_in      (clock_in),
      .nrst_in       (nrst_in),
      .ce_in         (ce_in),
      .in_valid_in   (push),
      .in_ready_out  (fifo_ready),
      .in_data_in    (rx_q),
      .out_valid_out (rd_valid_out),
      .out_ready_in  (rd_ready_in),
      .out_data_out  (rd_data_out)
   );

   assign cmd_ready_out    = (st_q == isap_pkg::ISAP_H_IDLE);
   assign bus.host_scl_oe  = scl_oe_q;
   assign bus.host_sda_oe  = sda_oe_q;
   assign bus.host_scl_out = 1'b0;
   assign bus.host_sda_out = 1'b0;

endmodule : isap_master

//--- inc/isap_pkg.sv
/*
 * Shared constants and types for the two-wire byte access port to a 64-byte
 * user memory: memory window, bit timing, command codes and state encodings.
 * Assumes a 100 MHz system clock on both ends and a pulled-up two-wire bus.
 */
package isap_pkg;

   localparam int       MEM_BYTES     = 64;
   localparam logic [6:0] MEM_FIRST   = 7'h20;
   localparam logic [6:0] MEM_LAST    = 7'h5f;
   localparam logic [6:0] PTR_RESET   = 7'h20;
   localparam logic [3:0] ACK_BIT     = 4'h8;
   localparam logic [6:0] TARGET_ADDR = 7'h5a;   // arbitrary bus address
   localparam int       CLK_PERIOD_NS = 10;
   // 1 MHz bus clock: still 25 system clocks a quarter, far above the 3-cycle sync latency
   localparam int       SCL_PERIOD_NS = 1000;
   localparam int       QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   localparam int       FIFO_DEPTH    = 8;

   typedef enum logic [1:0] {
      ISAP_OP_WRITE = 2'h0,
      ISAP_OP_CUR   = 2'h1,
      ISAP_OP_RAND  = 2'h2
   } isap_op_t;

   typedef enum logic [3:0] {
      ISAP_D_IDLE = 4'h0,
      ISAP_D_CTRL = 4'h1,
      ISAP_D_CACK = 4'h3,
      ISAP_D_WADR = 4'h2,
      ISAP_D_WACK = 4'h6,
      ISAP_D_WDAT = 4'h7,
      ISAP_D_DACK = 4'h5,
      ISAP_D_RDAT = 4'h4,
      ISAP_D_RACK = 4'hc
   } isap_dst_t;

   typedef enum logic [2:0] {
      ISAP_H_IDLE  = 3'h0,
      ISAP_H_START = 3'h1,
      ISAP_H_TX    = 3'h3,
      ISAP_H_RX    = 3'h2,
      ISAP_H_STOP  = 3'h6
   } isap_hst_t;

endpackage : isap_pkg

//--- inc/isap_bus_if.sv
/*
 * Two-wire bus between the memory target and the bus master.
 * Assumes open-drain pins with pull-ups: a line is low while any enable is high.
 */
`timescale 1ns/1ns
interface isap_bus_if;
   logic host_scl_out;
   logic host_scl_oe;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   logic scl_line;
   logic sda_line;

   // open drain: only a driven low wins, the pull-up gives the high
   assign scl_line = ~host_scl_oe;
   assign sda_line = ~(host_sda_oe | dev_sda_oe);

   modport device (input scl_line, input sda_line, output dev_sda_out, output dev_sda_oe);
   modport host   (input sda_line, input scl_line, output host_scl_out, output host_scl_oe,
                   output host_sda_out, output host_sda_oe);
endinterface : isap_bus_if

//--- hw/isap_target.sv
/*
 * Memory target end: decodes start/stop, control byte, word address and data,
 * and serves byte writes, current, random and sequential reads from 64 bytes.
 * Assumes the bus lines are asynchronous to clock_in and much slower than it.
 */
`timescale 1ns/1ns
module isap_target #(
   parameter logic [6:0] DEV_ADDR = isap_pkg::TARGET_ADDR
) (
   input  wire logic       clock_in,
   input  wire logic       nrst_in,
   input  wire logic       ce_in,
   isap_bus_if.device      bus,
   output logic            busy_out,
   output logic            wr_stb_out,
   output logic [6:0]      wr_addr_out,
   output logic [7:0]      wr_data_out
);

   function automatic logic [6:0] ptr_next(input logic [6:0] p);
      ptr_next = (p == isap_pkg::MEM_LAST) ? isap_pkg::MEM_FIRST : 7'(p + 7'h01);
   endfunction : ptr_next

   function automatic logic [5:0] mem_idx(input logic [6:0] p);
      mem_idx = 6'(p - isap_pkg::MEM_FIRST);
   endfunction : mem_idx

   logic [1:0]  scl_sync_q;
   logic [1:0]  sda_sync_q;
   logic        scl_q;
   logic        sda_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   isap_pkg::isap_dst_t st_q;
   logic [3:0]  cnt_q;
   logic [7:0]  sh_q;
   logic        oe_q;
   logic        rw_q;
   logic        mack_q;
   logic [6:0]  ptr_q;
   logic [7:0]  mem [isap_pkg::MEM_BYTES];
   logic [7:0]  rd_byte;
   logic        adr_ok;
   logic        adr_stb;
   logic        wr_stb;
   logic        ld_stb;

   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_q      <= 1'b1;
         sda_q      <= 1'b1;
      end
      else if (ce_in)
      begin
         scl_sync_q <= {scl_sync_q[0], bus.scl_line};
         sda_sync_q <= {sda_sync_q[0], bus.sda_line};
         scl_q      <= scl_sync_q[1];
         sda_q      <= sda_sync_q[1];
      end
   end

   assign scl_rise  = ce_in & scl_sync_q[1] & ~scl_q;
   assign scl_fall  = ce_in & ~scl_sync_q[1] & scl_q;
   assign start_det = ce_in & scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
   assign stop_det  = ce_in & scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];

   // addresses below the memory window belong to logic not present here
   assign adr_ok  = ~sh_q[7] && sh_q[6:0] >= isap_pkg::MEM_FIRST && sh_q[6:0] <= isap_pkg::MEM_LAST;
   assign adr_stb = scl_fall && st_q == isap_pkg::ISAP_D_WADR && cnt_q == isap_pkg::ACK_BIT && adr_ok;
   assign wr_stb  = scl_fall && st_q == isap_pkg::ISAP_D_WDAT && cnt_q == isap_pkg::ACK_BIT;
   assign ld_stb  = scl_fall && ((st_q == isap_pkg::ISAP_D_CACK && rw_q) ||
                                 (st_q == isap_pkg::ISAP_D_RACK && mack_q));
   assign rd_byte = mem[mem_idx(ptr_q)];

   // protocol sequencer; start and stop override every state
   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         st_q   <= isap_pkg::ISAP_D_IDLE;
         cnt_q  <= 4'h0;
         sh_q   <= 8'h00;
         oe_q   <= 1'b0;
         rw_q   <= 1'b0;
         mack_q <= 1'b0;
      end
      else if (start_det)
      begin
         st_q  <= isap_pkg::ISAP_D_CTRL;
         cnt_q <= 4'h0;
         oe_q  <= 1'b0;
      end
      else if (stop_det)
      begin
         st_q <= isap_pkg::ISAP_D_IDLE;
         oe_q <= 1'b0;
      end
      else
      begin
         case (st_q)
            isap_pkg::ISAP_D_CTRL, isap_pkg::ISAP_D_WADR, isap_pkg::ISAP_D_WDAT:
            begin
               if (scl_rise)
               begin
                  sh_q  <= {sh_q[6:0], sda_sync_q[1]};
                  cnt_q <= 4'(cnt_q + 4'h1);
               end
               else if (scl_fall && cnt_q == isap_pkg::ACK_BIT)
               begin
                  cnt_q <= 4'h0;
                  if (st_q == isap_pkg::ISAP_D_CTRL)
                  begin
                     if (sh_q[7:1] == DEV_ADDR)
                     begin
                        oe_q <= 1'b1;
                        rw_q <= sh_q[0];
                        st_q <= isap_pkg::ISAP_D_CACK;
                     end
                     else
                        st_q <= isap_pkg::ISAP_D_IDLE;
                  end
                  else if (st_q == isap_pkg::ISAP_D_WADR)
                  begin
                     oe_q <= adr_ok;
                     st_q <= adr_ok ? isap_pkg::ISAP_D_WACK : isap_pkg::ISAP_D_IDLE;
                  end
                  else
                  begin
                     oe_q <= 1'b1;
                     st_q <= isap_pkg::ISAP_D_DACK;
                  end
               end
            end
            isap_pkg::ISAP_D_CACK:
            begin
               if (scl_fall && rw_q)
               begin
                  sh_q  <= rd_byte;
                  oe_q  <= ~rd_byte[7];
                  cnt_q <= 4'h1;
                  st_q  <= isap_pkg::ISAP_D_RDAT;
               end
               else if (scl_fall)
               begin
                  oe_q <= 1'b0;
                  st_q <= isap_pkg::ISAP_D_WADR;
               end
            end
            isap_pkg::ISAP_D_WACK, isap_pkg::ISAP_D_DACK:
            begin
               if (scl_fall)
               begin
                  oe_q <= 1'b0;
                  st_q <= isap_pkg::ISAP_D_WDAT;
               end
            end
            isap_pkg::ISAP_D_RDAT:
            begin
               if (scl_fall && cnt_q == isap_pkg::ACK_BIT)
               begin
                  oe_q <= 1'b0;  // master owns the ninth bit
                  st_q <= isap_pkg::ISAP_D_RACK;
               end
               else if (scl_fall)
               begin
                  oe_q  <= ~sh_q[6];
                  sh_q  <= {sh_q[6:0], 1'b0};
                  cnt_q <= 4'(cnt_q + 4'h1);
               end
            end
            isap_pkg::ISAP_D_RACK:
            begin
               if (scl_rise)
                  mack_q <= ~sda_sync_q[1];
               else if (scl_fall && mack_q)
               begin
                  sh_q  <= rd_byte;
                  oe_q  <= ~rd_byte[7];
                  cnt_q <= 4'h1;
                  st_q  <= isap_pkg::ISAP_D_RDAT;
               end
               else if (scl_fall)
                  st_q <= isap_pkg::ISAP_D_IDLE;
            end
            default:
            begin
               oe_q <= 1'b0;
            end
         endcase
      end
   end

   // address pointer
   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
         ptr_q <= isap_pkg::PTR_RESET;
      else if (start_det || stop_det)
         ptr_q <= ptr_q;
      else if (adr_stb)
         ptr_q <= sh_q[6:0];
      else if (wr_stb || ld_stb)
         ptr_q <= ptr_next(ptr_q);
   end

   // user memory is not reset, so it powers up holding whatever it holds
   always_ff @(posedge clock_in)
   begin
      if (wr_stb && !start_det && !stop_det)
         mem[mem_idx(ptr_q)] <= sh_q;
   end

   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         wr_stb_out  <= 1'b0;
         wr_addr_out <= 7'h00;
         wr_data_out <= 8'h00;
      end
      else if (ce_in)
      begin
         wr_stb_out <= wr_stb && !start_det && !stop_det;
         if (wr_stb)
         begin
            wr_addr_out <= ptr_q;
            wr_data_out <= sh_q;
         end
      end
   end

   assign busy_out        = (st_q != isap_pkg::ISAP_D_IDLE);
   assign bus.dev_sda_oe  = oe_q;
   assign bus.dev_sda_out = 1'b0;

endmodule : isap_target

//--- tb/isap_props.sv
/*
 * Checker of the two-wire link between the master end and the memory target.
 * Assumes the interface signals arrive by name, all in the clock_in domain.
 */
`timescale 1ns/1ns
module isap_props (
   input  wire logic clock_in,
   input  wire logic nrst_in,
   input  wire logic host_scl_oe,
   input  wire logic host_sda_oe,
   input  wire logic dev_sda_oe,
   input  wire logic scl_line,
   input  wire logic sda_line
);
   default clocking dcb @(posedge clock_in);
   endclocking
   default disable iff (!nrst_in);

   a_dev_pull_low: assert property ($rose(dev_sda_oe) |-> !scl_line)
      else $error("target pulled sda while scl high");
   a_dev_free_low: assert property ($fell(dev_sda_oe) |-> !scl_line)
      else $error("target released sda while scl high");
   a_dev_bit_stands: assert property (dev_sda_oe && $rose(scl_line) |-> dev_sda_oe[*8])
      else $error("target bit changed during scl high");
   a_start_then_low: assert property ($fell(sda_line) && scl_line |-> ##[20:30] !scl_line)
      else $error("scl not pulled after start");
   a_stop_bus_idle: assert property ($rose(sda_line) && scl_line |=> (sda_line && scl_line)[*8])
      else $error("bus not idle after stop");
   a_scl_low_min: assert property ($rose(host_scl_oe) |=> host_scl_oe[*8])
      else $error("scl low phase too short");
   a_scl_high_min: assert property ($fell(host_scl_oe) |=> !host_scl_oe[*8])
      else $error("scl high phase too short");
   a_start_by_host: assert property ($fell(sda_line) && scl_line |-> host_sda_oe && !dev_sda_oe)
      else $error("start not made by the master");

   cover property ($rose(dev_sda_oe));
   cover property ($fell(sda_line) && scl_line);
   cover property ($rose(sda_line) && scl_line);
endmodule : isap_props

//--- tb/i2c_sram_access_port_bench.sv
/*
 * Bench: master and target joined by the link; a model memory checks writes and reads.
 * Assumes a 100 MHz clock_in and the pulled-up bus interface.
 */
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
   $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module i2c_sram_access_port_bench;
   logic        clock_in, nrst_in, cmd_valid, rd_ready, cmd_ready, rd_valid, done, nack, busy, wr_stb;
   logic [1:0]  cmd_op;
   logic [6:0]  cmd_addr, cmd_len, wr_addr;
   logic [7:0]  cmd_data, rd_data, wr_data, d;
   logic [7:0]  mem [0:127];
   bit          known [0:127];
   logic [7:0]  rxq [$];
   logic [14:0] wv, wq [$];
   logic [6:0]  wa [3] = '{7'h21, 7'h20, 7'h5f};
   logic [6:0]  ba [2] = '{7'h60, 7'h1f};
   logic [31:0] seed;
   int          error_cnt, cmp_count, ptr, k, cnt;

   isap_bus_if bus_if ();
   isap_target isap_target_inst (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(1'b1), .bus(bus_if),
      .busy_out(busy), .wr_stb_out(wr_stb), .wr_addr_out(wr_addr), .wr_data_out(wr_data));
   isap_master isap_master_inst (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(1'b1), .bus(bus_if),
      .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr),
      .cmd_data_in(cmd_data), .cmd_len_in(cmd_len), .rd_valid_out(rd_valid), .rd_ready_in(rd_ready),
      .rd_data_out(rd_data), .done_out(done), .nack_out(nack));
   isap_props isap_props_inst (.clock_in(clock_in), .nrst_in(nrst_in), .host_scl_oe(bus_if.host_scl_oe),
      .host_sda_oe(bus_if.host_sda_oe), .dev_sda_oe(bus_if.dev_sda_oe), .scl_line(bus_if.scl_line),
      .sda_line(bus_if.sda_line));

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs

   // pointer model: one past, wrapping inside the window
   function automatic int nxt(input int p);
      return (p == 'h5f) ? 'h20 : p + 1;
   endfunction : nxt

   always @(posedge clock_in)
   begin
      if (rd_valid && rd_ready)
         rxq.push_back(rd_data);
      if (wr_stb)
         wq.push_back({wr_addr, wr_data});
   end

   task wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   task run(input logic [1:0] op, input logic [6:0] a, input logic [7:0] dv, input logic [6:0] n);
      int i;
      cmd_op    <= op;
      cmd_addr  <= a;
      cmd_data  <= dv;
      cmd_len   <= n;
      cmd_valid <= 1'b1;
      for (i = 0; i < 10; i++)
      begin
         @(posedge clock_in);
         if (cmd_ready === 1'b1)
            break;
      end
      if (cmd_ready !== 1'b1)
      begin
         error_cnt++;
         $display("[FAIL] %0t command not taken", $time);
      end
      cmd_valid <= 1'b0;
      for (i = 0; i < 30000 && done !== 1'b1; i++)
         @(posedge clock_in);
      if (done !== 1'b1)
      begin
         error_cnt++;
         $display("[FAIL] %0t command hung", $time);
         wrap_up();
      end
   endtask : run

   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   initial
   begin
      nrst_in = 1'b0;
      cmd_valid = 1'b0;
      rd_ready = 1'b1;
      cmd_op = 2'h0;
      cmd_addr = 7'h00;
      cmd_data = 8'h00;
      cmd_len = 7'h00;
      seed = 32'he80e4fbe;
      ptr = 'h20;
      repeat (2) @(posedge clock_in);
      nrst_in <= 1'b1;
      for (k = 0; k < 3; k++)
      begin
         seed = xs(seed);
         d = seed[7:0];
         run(2'h0, wa[k], d, 7'h01);
         `CHK(nack, 1'b0)
         wv = wq.pop_front();
         `CHK(wv, {wa[k], d})
         mem[wa[k]] = d;
         known[wa[k]] = 1'b1;
         ptr = nxt(wa[k]);
      end
      $display("byte writes done");
      run(2'h1, 7'h00, 8'h00, 7'h01);
      d = rxq.pop_front();
      `CHK(d, mem[ptr])
      `CHK(busy, 1'b0)
      $display("current read done");
      // hold the sink off so the buffer fills and the master must stall the clock
      rd_ready <= 1'b0;
      fork
         run(2'h2, 7'h5f, 8'h00, 7'h0a);
         begin
            cnt = 0;
            for (k = 0; k < 30000 && cnt < 3000; k++)
            begin
               @(posedge clock_in);
               cnt = bus_if.scl_line ? 0 : cnt + 1;
            end
            `CHK(cnt >= 3000, 1'b1)
            rd_ready <= 1'b1;
         end
      join
      `CHK(rxq.size(), 10)
      ptr = 'h5f;
      for (k = 0; k < 10; k++)
      begin
         d = rxq.pop_front();
         if (known[ptr])
            `CHK(d, mem[ptr])
         ptr = nxt(ptr);
      end
      $display("sequential read done");
      for (k = 0; k < 2; k++)
      begin
         run(2'h0, ba[k], 8'h00, 7'h01);
         `CHK(nack, 1'b1)
         `CHK(wq.size(), 0)
      end
      $display("refused addresses done");
      wrap_up();
   end
endmodule : i2c_sram_access_port_bench
